//--- pkg/yts_pkg.sv
/*
 * constants, types and date helpers of the yearly switch block.
 * assumes the calendar comes in as day, month and full binary year,
 * already synchronous to sys_clk_in.
 */
package yts_pkg;

   // ******************************************************************
   // sizes
   // ******************************************************************
   localparam int          YTS_NUM_INST    = 32;
   localparam int          YTS_NUM_CHAN    = 4;
   localparam int          YTS_DAY_W       = 5;
   localparam int          YTS_MON_W       = 4;
   localparam int          YTS_YR_W        = 7;
   localparam int          YTS_FULL_YR_W   = 12;
   localparam int          YTS_KEY_W       = 16;

   // ******************************************************************
   // year window and reset values
   // ******************************************************************
   localparam logic [11:0] YTS_YEAR_BASE   = 12'h7d0;
   localparam logic [11:0] YTS_YEAR_MAX    = 12'h833;
   localparam logic [6:0]  YTS_YR_NONE     = 7'h7f;
   localparam logic [31:0] YTS_RECOMP_RST  = 32'hffffffff;
   localparam logic [31:0] YTS_SW_RST      = 32'h00000000;

   // ******************************************************************
   // types
   // ******************************************************************
   typedef struct packed {
      logic                 use_yr;
      logic                 use_mon;
      logic                 use_day;
      logic [YTS_YR_W-1:0]  yr;
      logic [YTS_MON_W-1:0] mon;
      logic [YTS_DAY_W-1:0] day;
   } yts_point_t;

   typedef struct packed {
      logic       on_set;
      logic       off_set;
      yts_point_t on_pt;
      yts_point_t off_pt;
   } yts_chan_t;

   // ******************************************************************
   // helpers
   // ******************************************************************
   function automatic logic yts_year_ok(input logic [11:0] year);
      return (year >= YTS_YEAR_BASE) && (year <= YTS_YEAR_MAX);
   endfunction : yts_year_ok

   // years outside 2000..2099 map to a value no setting can hold
   function automatic logic [6:0] yts_year_off(input logic [11:0] year);
      logic [11:0] diff;
      diff = year - YTS_YEAR_BASE;
      return yts_year_ok(year) ? diff[6:0] : YTS_YR_NONE;
   endfunction : yts_year_off

   // date key holding only the fields that a setting uses
   function automatic logic [15:0] yts_key(input yts_point_t use_pt,
                                           input logic [6:0] yr,
                                           input logic [3:0] mon,
                                           input logic [4:0] day);
      return {(use_pt.use_yr  ? yr  : 7'h00),
              (use_pt.use_mon ? mon : 4'h0),
              (use_pt.use_day ? day : 5'h00)};
   endfunction : yts_key

   // day inside [on, off], both ends inclusive
   function automatic logic yts_in_range(input yts_point_t on_pt,
                                         input yts_point_t off_pt,
                                         input logic [6:0] yr,
                                         input logic [3:0] mon,
                                         input logic [4:0] day);
      logic [15:0] cur;
      cur = yts_key(on_pt, yr, mon, day);
      return (cur >= yts_key(on_pt, on_pt.yr, on_pt.mon, on_pt.day)) &&
             (cur <= yts_key(off_pt, off_pt.yr, off_pt.mon, off_pt.day));
   endfunction : yts_in_range

endpackage : yts_pkg

//--- hdl/yts_channel_eval.sv
/*
 * range evaluation of the four channels of one yearly switch instance.
 * assumes channel settings and the current date are stable registers;
 * purely combinational, the caller registers the result.
 */
`timescale 1ns/10ps
module yts_channel_eval
   import yts_pkg::*;
(
   input  yts_chan_t  [3:0] chan_in,     // settings of channels a..d
   input  wire logic  [6:0] cur_yr_in,   // current year minus 2000
   input  wire logic  [3:0] cur_mon_in,  // current month
   input  wire logic  [4:0] cur_day_in,  // current day of month
   output logic       [3:0] active_out   // channel range holds today
);

   // ******************************************************************
   // per channel: single range or range paired with the next channel
   // ******************************************************************
   always_comb
   begin
      active_out = 4'h0;
      for (int k = 0; k < YTS_NUM_CHAN; k++)
      begin
         if (chan_in[k].on_set && chan_in[k].off_set)
         begin
            // recurring interval held in one channel
            active_out[k] = yts_in_range(chan_in[k].on_pt,
                                         chan_in[k].off_pt, cur_yr_in,
                                         cur_mon_in, cur_day_in);
         end
         else if ((k < YTS_NUM_CHAN - 1) && chan_in[k].on_set &&
                  !chan_in[(k+1)%YTS_NUM_CHAN].on_set &&
                  chan_in[(k+1)%YTS_NUM_CHAN].off_set)
         begin
            // continuous period: on here, off in the next channel
            active_out[k] = yts_in_range(chan_in[k].on_pt,
                               chan_in[(k+1)%YTS_NUM_CHAN].off_pt,
                               cur_yr_in, cur_mon_in,
                               cur_day_in);
         end
      end
   end

endmodule : yts_channel_eval

//--- hdl/yts_top.sv
/*
 * 32 yearly switch instances with four channels each, one switch
 * output per instance, compared against a battery-backed calendar.
 * assumes the calendar inputs are synchronous to sys_clk_in and change
 * at most once per day; settings arrive over a plain write strobe.
 */
// Behaviour
// - 32 independent instances, each with own settings and own output.
// - four channels a..d per instance, all acting on one output.
// - settings and comparison are whole calendar days only.
// - recurring day, month or year interval uses on and off of one channel.
// - continuous period: on from one channel, off from the next.
// - continuous period output stays on from start to final day end.
// - overlapping ranges: first on event from any channel sets output.
// - first off event from any channel clears output despite other ranges.
// - without main power no switching, output held at zero.
// - year settings above 2099 are refused.
// - with enable evaluation on, instance works only while enable is one.
// - output is one while a range holds, but cleared by any off event until the next on event.
// - off day inclusive: off at start of the following day.
`timescale 1ns/10ps
module yts_top
   import yts_pkg::*;
(
   input  wire logic        sys_clk_in,      // 200 mhz system clock
   input  wire logic        rst_in,          // synchronous reset, high
   input  wire logic [4:0]  rtc_day_in,      // calendar day 1..31
   input  wire logic [3:0]  rtc_month_in,    // calendar month 1..12
   input  wire logic [11:0] rtc_year_in,     // calendar year, binary
   input  wire logic        power_ok_in,     // main power present
   input  wire logic [31:0] en_eval_in,      // per instance: use enable
   input  wire logic [31:0] enable_in,       // per instance enable input
   input  wire logic        cfg_we_in,       // setting write strobe
   input  wire logic [4:0]  cfg_inst_in,     // instance written
   input  wire logic [1:0]  cfg_chan_in,     // channel written, 0 = a
   input  wire logic        cfg_off_in,      // 1: off point, 0: on point
   input  wire logic        cfg_use_day_in,  // day field filled
   input  wire logic        cfg_use_mon_in,  // month field filled
   input  wire logic        cfg_use_yr_in,   // year field filled
   input  wire logic [4:0]  cfg_day_in,      // day of the point
   input  wire logic [3:0]  cfg_month_in,    // month of the point
   input  wire logic [11:0] cfg_year_in,     // full year of the point
   output      logic [31:0] switch_output_out, // per instance switch
   output      logic        cfg_reject_out     // write of the previous cycle was refused
);

   // ******************************************************************
   // state
   // ******************************************************************
   typedef struct packed {
      yts_chan_t [31:0][3:0] cfg;
      logic      [31:0][3:0] prev_act;
      logic      [31:0]      sw;
      logic      [31:0]      recompute;
      logic                  reject;
   } yts_state_t;

   yts_state_t              state_ff;
   yts_state_t              nxt_state;
   logic       [31:0][3:0]  act;
   logic       [6:0]        cur_yr;
   yts_point_t              wr_pt;

   // ******************************************************************
   // helpers
   // ******************************************************************
   // a point counts as set once any of its fields is filled
   function automatic logic yts_pt_used(input yts_point_t pt);
      return pt.use_yr | pt.use_mon | pt.use_day;
   endfunction : yts_pt_used

   // stored point: unused fields kept at zero so keys compare cleanly
   function automatic yts_point_t yts_make_point(input logic        use_yr,
                                                 input logic        use_mon,
                                                 input logic        use_day,
                                                 input logic [11:0] year,
                                                 input logic [3:0]  mon,
                                                 input logic [4:0]  day);
      yts_point_t pt;
      pt.use_yr  = use_yr;
      pt.use_mon = use_mon;
      pt.use_day = use_day;
      pt.yr      = use_yr ? yts_year_off(year) : 7'h00;
      pt.mon     = use_mon ? mon : 4'h0;
      pt.day     = use_day ? day : 5'h00;
      return pt;
   endfunction : yts_make_point

   // ******************************************************************
   // switching step of one instance, returns {switch, recompute}
   // ******************************************************************
   // off is tested before on: an on and an off in one cycle leave it open
   function automatic logic [1:0] yts_step(input logic       pwr_ok,
                                           input logic       gated,
                                           input logic       redo,
                                           input logic       sw,
                                           input logic [3:0] act_now,
                                           input logic [3:0] act_old);
      logic rise;
      logic fall;
      logic sw_n;
      logic redo_n;
      rise   = |(act_now & ~act_old);
      fall   = |(~act_now & act_old);
      sw_n   = sw;
      redo_n = redo;
      if (!pwr_ok)
      begin
         // calendar keeps running outside; outputs stay open
         sw_n   = 1'b0;
         redo_n = 1'b1;
      end
      else if (gated)
      begin
         sw_n   = 1'b0;
         redo_n = 1'b1;
      end
      else if (redo)
      begin
         // full re-evaluation, no wait for the next event
         sw_n   = |act_now;
         redo_n = 1'b0;
      end
      else if (fall)
      begin
         // an off event wins even while other ranges hold
         sw_n = 1'b0;
      end
      else if (rise)
      begin
         sw_n = 1'b1;
      end
      return {sw_n, redo_n};
   endfunction : yts_step

   // day resolution only: no time of day enters the comparison
   assign cur_yr = yts_year_off(rtc_year_in);

   // ******************************************************************
   // range evaluation, one evaluator per instance
   // ******************************************************************
   for (genvar i = 0; i < YTS_NUM_INST; i++)
   begin : g_inst
      yts_channel_eval u_eval (
         .chan_in    (state_ff.cfg[i]),
         .cur_yr_in  (cur_yr),
         .cur_mon_in (rtc_month_in),
         .cur_day_in (rtc_day_in),
         .active_out (act[i])
      );
   end

   // ******************************************************************
   // next state
   // ******************************************************************
   always_comb
   begin
      nxt_state        = state_ff;
      nxt_state.reject = 1'b0;
      wr_pt            = yts_make_point(cfg_use_yr_in, cfg_use_mon_in,
                                        cfg_use_day_in, cfg_year_in,
                                        cfg_month_in, cfg_day_in);

      // setting writes; a point with no field filled clears it
      if (cfg_we_in)
      begin
         if (cfg_use_yr_in && !yts_year_ok(cfg_year_in))
         begin
            nxt_state.reject = 1'b1;
         end
         else if (cfg_off_in)
         begin
            nxt_state.cfg[cfg_inst_in][cfg_chan_in].off_pt  = wr_pt;
            nxt_state.cfg[cfg_inst_in][cfg_chan_in].off_set =
               yts_pt_used(wr_pt);
         end
         else
         begin
            nxt_state.cfg[cfg_inst_in][cfg_chan_in].on_pt  = wr_pt;
            nxt_state.cfg[cfg_inst_in][cfg_chan_in].on_set =
               yts_pt_used(wr_pt);
         end
      end

      // switching per instance
      for (int i = 0; i < YTS_NUM_INST; i++)
      begin
         nxt_state.prev_act[i] = act[i];
         {nxt_state.sw[i], nxt_state.recompute[i]} =
            yts_step(power_ok_in, en_eval_in[i] && !enable_in[i],
                     state_ff.recompute[i], state_ff.sw[i], act[i],
                     state_ff.prev_act[i]);
      end
   end

   // ******************************************************************
   // registers
   // ******************************************************************
   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
      begin
         state_ff           <= '0;
         state_ff.sw        <= YTS_SW_RST;
         state_ff.recompute <= YTS_RECOMP_RST;
      end
      else
      begin
         state_ff <= nxt_state;
      end
   end

   assign switch_output_out = state_ff.sw;
   assign cfg_reject_out    = state_ff.reject;

endmodule : yts_top

//--- verification/yts_asserts.sv
/* port checker of the yearly switch block.
   bound to every yts_top; one clock domain, sync reset. */
`timescale 1ns/10ps
module yts_asserts
   import yts_pkg::*;
(
   input wire logic        sys_clk_in,        // clock
   input wire logic        rst_in,            // sync reset
   input wire logic [4:0]  rtc_day_in,        // day
   input wire logic [3:0]  rtc_month_in,      // month
   input wire logic [11:0] rtc_year_in,       // year
   input wire logic        power_ok_in,       // power
   input wire logic [31:0] en_eval_in,        // enable used
   input wire logic [31:0] enable_in,         // enable
   input wire logic        cfg_we_in,         // write
   input wire logic        cfg_use_yr_in,     // year used
   input wire logic [11:0] cfg_year_in,       // year set
   input wire logic [31:0] switch_output_out, // switches
   input wire logic        cfg_reject_out     // refused
);
   logic bad_wr;
   assign bad_wr = cfg_we_in && cfg_use_yr_in &&
      (cfg_year_in < YTS_YEAR_BASE || cfg_year_in > YTS_YEAR_MAX);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);
   // ******************************************************************
   // properties
   // ******************************************************************
   sequence s_quiet;
      (!cfg_we_in && power_ok_in && $stable(enable_in) &&
       $stable(en_eval_in) &&
       $stable({rtc_day_in, rtc_month_in, rtc_year_in}))[*3];
   endsequence
   property p_quiet; s_quiet |-> $stable(switch_output_out); endproperty
   property p_no_pwr; !power_ok_in |=> switch_output_out == 32'h0;
   endproperty
   property p_pwr_hold; !power_ok_in [*2] |-> switch_output_out == 32'h0;
   endproperty
   property p_rise_pwr;
      (switch_output_out & ~$past(switch_output_out)) != 32'h0
         |-> $past(power_ok_in);
   endproperty
   property p_en_low; (en_eval_in & ~enable_in) != 32'h0
      |=> (switch_output_out & $past(en_eval_in & ~enable_in)) == 32'h0;
   endproperty
   property p_reject; bad_wr |=> cfg_reject_out; endproperty
   property p_accept; cfg_we_in && !bad_wr |=> !cfg_reject_out;
   endproperty
   property p_cause; cfg_reject_out |-> $past(bad_wr); endproperty
   a_quiet: assert property (p_quiet)
      else $error("output moved");
   a_no_pwr: assert property (p_no_pwr)
      else $error("on sans power");
   a_pwr_hold: assert property (p_pwr_hold)
      else $error("on sans power");
   a_rise_pwr: assert property (p_rise_pwr)
      else $error("rise no power");
   a_en_low: assert property (p_en_low)
      else $error("on sans enable");
   a_reject: assert property (p_reject)
      else $error("no refusal");
   a_accept: assert property (p_accept)
      else $error("bad refusal");
   a_cause: assert property (p_cause)
      else $error("stray refusal");
endmodule : yts_asserts

bind yts_top yts_asserts u_asserts
(
   .sys_clk_in(sys_clk_in), .rst_in(rst_in), .rtc_day_in(rtc_day_in),
   .rtc_month_in(rtc_month_in), .rtc_year_in(rtc_year_in),
   .power_ok_in(power_ok_in), .en_eval_in(en_eval_in),
   .enable_in(enable_in), .cfg_we_in(cfg_we_in),
   .cfg_use_yr_in(cfg_use_yr_in), .cfg_year_in(cfg_year_in),
   .switch_output_out(switch_output_out), .cfg_reject_out(cfg_reject_out)
);

//--- verification/yts_rtc_model.sv
/* battery-backed calendar seen by the yearly switch.
   assumes the bench moves the date only at falling clock edges. */
`timescale 1ns/10ps
module yts_rtc_model
(
   input  wire logic  clk_in,    // system clock
   output logic [4:0] day_out,   // day of month
   output logic [3:0] month_out, // month
   output logic [11:0] year_out  // full binary year
);
   initial
   begin
      day_out = 5'h01;
      month_out = 4'h1;
      year_out = 12'h7d0;
   end
   task automatic set_date(input logic [4:0] d, input logic [3:0] m,
                           input logic [11:0] y);
      @(negedge clk_in);
      day_out = d;
      month_out = m;
      year_out = y;
   endtask : set_date
endmodule : yts_rtc_model

//--- verification/year_time_switch_test.sv
/* self-checking bench of yts_top.
   assumes the rtc model and the checker bind are compiled before it. */
`timescale 1ns/10ps
module year_time_switch_test;
   logic clk = 1'b0, rst = 1'b1, pwr = 1'b1, we = 1'b0, off = 1'b0, rej;
   logic [31:0] eval = 32'h0, en = 32'hffffffff, sw;
   logic [4:0] inst = 5'h0, cd = 5'h0, day;
   logic [3:0] cm = 4'h0, mon;
   logic [11:0] cy = 12'h0, yr;
   logic [1:0] chan = 2'h0;
   logic [2:0] u = 3'h0;
   int n_mismatch = 0, checks = 0;
   always #2.5 clk = ~clk;
   yts_rtc_model u_rtc (.clk_in(clk), .day_out(day), .month_out(mon),
                        .year_out(yr));
   yts_top u_dut (.sys_clk_in(clk), .rst_in(rst), .rtc_day_in(day),
      .rtc_month_in(mon), .rtc_year_in(yr), .power_ok_in(pwr),
      .en_eval_in(eval), .enable_in(en), .cfg_we_in(we),
      .cfg_inst_in(inst), .cfg_chan_in(chan), .cfg_off_in(off),
      .cfg_use_day_in(u[0]), .cfg_use_mon_in(u[1]), .cfg_use_yr_in(u[2]),
      .cfg_day_in(cd), .cfg_month_in(cm), .cfg_year_in(cy),
      .switch_output_out(sw), .cfg_reject_out(rej));
   // ******************************************************************
   // tasks
   // ******************************************************************
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [4:0] i, input logic [1:0] c,
      input logic o, input logic [2:0] f, input logic [4:0] d,
      input logic [3:0] m, input logic [11:0] y);
      @(negedge clk);
      {we, inst, chan, off, u, cd, cm, cy} = {1'b1, i, c, o, f, d, m, y};
      @(negedge clk);
      we = 1'b0;
   endtask : wr
   task automatic see(input logic [4:0] d, input logic [3:0] m,
      input logic [11:0] y, input logic [31:0] k, input logic [31:0] e);
      u_rtc.set_date(d, m, y);
      repeat (2) @(negedge clk);
      chk(sw & k, e);
   endtask : see
   task automatic t_recur;
      wr(5'h00, 2'h0, 1'b0, 3'h1, 5'h02, 4'h0, 12'h0);
      wr(5'h00, 2'h0, 1'b1, 3'h1, 5'h19, 4'h0, 12'h0);
      wr(5'h01, 2'h0, 1'b0, 3'h2, 5'h00, 4'h4, 12'h0);
      wr(5'h01, 2'h0, 1'b1, 3'h2, 5'h00, 4'ha, 12'h0);
      see(5'h01, 4'h3, 12'h7e6, 32'h3, 32'h0);
      see(5'h02, 4'h4, 12'h7e6, 32'h3, 32'h3);
      see(5'h19, 4'ha, 12'h7e6, 32'h3, 32'h3);
      see(5'h1a, 4'ha, 12'h7e6, 32'h3, 32'h2);
      see(5'h01, 4'hb, 12'h7e6, 32'h3, 32'h0);
      $display("t_recur done");
   endtask : t_recur
   task automatic t_cont;
      wr(5'h02, 2'h0, 1'b0, 3'h7, 5'h05, 4'h3, 12'h7e6);
      wr(5'h02, 2'h1, 1'b1, 3'h7, 5'h07, 4'h3, 12'h7e6);
      see(5'h04, 4'h3, 12'h7e6, 32'h4, 32'h0);
      see(5'h05, 4'h3, 12'h7e6, 32'h4, 32'h4);
      see(5'h07, 4'h3, 12'h7e6, 32'h4, 32'h4);
      see(5'h08, 4'h3, 12'h7e6, 32'h4, 32'h0);
      $display("t_cont done");
   endtask : t_cont
   task automatic t_overlap;
      wr(5'h03, 2'h0, 1'b0, 3'h1, 5'h05, 4'h0, 12'h0);
      wr(5'h03, 2'h0, 1'b1, 3'h1, 5'h14, 4'h0, 12'h0);
      wr(5'h03, 2'h1, 1'b0, 3'h1, 5'h0a, 4'h0, 12'h0);
      wr(5'h03, 2'h1, 1'b1, 3'h1, 5'h0f, 4'h0, 12'h0);
      see(5'h04, 4'h1, 12'h7e6, 32'h8, 32'h0);
      see(5'h05, 4'h1, 12'h7e6, 32'h8, 32'h8);
      see(5'h0a, 4'h1, 12'h7e6, 32'h8, 32'h8);
      see(5'h10, 4'h1, 12'h7e6, 32'h8, 32'h0);
      see(5'h11, 4'h1, 12'h7e6, 32'h8, 32'h0);
      $display("t_overlap done");
   endtask : t_overlap
   task automatic t_year;
      wr(5'h04, 2'h0, 1'b0, 3'h4, 5'h00, 4'h0, 12'h834);
      chk({31'h0, rej}, 32'h1);
      wr(5'h04, 2'h0, 1'b0, 3'h4, 5'h00, 4'h0, 12'h833);
      chk({31'h0, rej}, 32'h0);
      wr(5'h04, 2'h0, 1'b1, 3'h4, 5'h00, 4'h0, 12'h833);
      see(5'h01, 4'h1, 12'h833, 32'h10, 32'h10);
      see(5'h01, 4'h1, 12'h834, 32'h10, 32'h0);
      $display("t_year done");
   endtask : t_year
   task automatic t_power_enable;
      see(5'h0a, 4'h1, 12'h7e6, 32'h1, 32'h1);
      pwr = 1'b0;
      repeat (2) @(negedge clk);
      chk(sw, 32'h0);
      pwr = 1'b1;
      repeat (2) @(negedge clk);
      chk(sw & 32'h1, 32'h1);
      {eval[0], en[0]} = 2'b10;
      repeat (2) @(negedge clk);
      chk(sw & 32'h1, 32'h0);
      en[0] = 1'b1;
      repeat (2) @(negedge clk);
      chk(sw & 32'h1, 32'h1);
      {eval[0], en[0]} = 2'b00;
      repeat (2) @(negedge clk);
      chk(sw & 32'h1, 32'h1);
      wr(5'h00, 2'h0, 1'b1, 3'h0, 5'h00, 4'h0, 12'h0);
      @(negedge clk);
      chk(sw & 32'h1, 32'h0);
      $display("t_power_enable done");
   endtask : t_power_enable
   task automatic conclude;
      $display("checks=%0d mismatches=%0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : conclude
   initial
   begin
      #20000;
      n_mismatch++;
      conclude;
   end
   initial
   begin
      repeat (3) @(negedge clk);
      rst = 1'b0;
      t_recur;
      t_cont;
      t_overlap;
      t_year;
      t_power_enable;
      conclude;
   end
endmodule : year_time_switch_test
